// ### rtl/mac_eee_pkg.sv
// Purpose: shared constants and types for the eee and duplex control block
// Assumes: axi4-lite register bus, 32-bit data, 12-bit byte address
// Notes:   reset values of the protected eee fields are plain defaults
package mac_eee_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W          = 12;
  localparam logic [11:0] OFF_MAC_CONTROL = 12'h100;
  localparam logic [11:0] OFF_AUX_CONTROL = 12'h104;
  localparam logic [11:0] OFF_EXIT_DELAY  = 12'h108;
  localparam logic [11:0] OFF_STATUS      = 12'h10c;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int unsigned CTL_CLK_HALT_BIT  = 18;
  localparam int unsigned CTL_EEE_ON_BIT    = 17;
  localparam int unsigned CTL_AUTO_EXIT_BIT = 16;
  localparam int unsigned CTL_DPX_POL_BIT   = 13;
  localparam int unsigned CTL_AUTO_DPX_BIT  = 12;
  localparam int unsigned AUX_DPX_BIT       = 0;
  localparam int unsigned AUX_RX_ON_BIT     = 1;
  localparam int unsigned AUX_TX_ON_BIT     = 2;
  localparam int unsigned AUX_LINK_100_BIT  = 3;
  localparam int unsigned AUX_LPI_REQ_BIT   = 4;
  localparam int unsigned AUX_PROTECT_BIT   = 5;
  localparam int unsigned AUX_SOFT_RST_BIT  = 6;
  localparam int unsigned STS_TX_LPI_BIT    = 0;
  localparam int unsigned STS_RX_LPI_BIT    = 1;
  localparam int unsigned STS_FULL_DPX_BIT  = 2;
  localparam int unsigned STS_HALT_BIT      = 3;

  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic        RST_CLK_HALT   = 1'h0;
  localparam logic        RST_EEE_ON     = 1'h0;
  localparam logic        RST_AUTO_EXIT  = 1'h0;
  localparam logic        RST_DPX_POL    = 1'h1;
  localparam logic        RST_AUTO_DPX   = 1'h0;
  localparam logic [31:0] RST_EXIT_DELAY = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [7:0]  GMII_LPI_CODE  = 8'h01;
  localparam logic [7:0]  GMII_IDLE_CODE = 8'h00;

  typedef struct packed {
    logic clk_halt;
    logic eee_on;
    logic auto_exit;
    logic dpx_pol;
    logic auto_dpx;
  } mac_control_type;

  typedef struct packed {
    logic duplex_mode_bit;
    logic rx_on;
    logic tx_on;
    logic link_100;
    logic lpi_req;
    logic protect;
  } aux_control_type;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic [7:0] d;
  } gmii_rx_type;

  typedef enum logic [1:0] {LPI_OFF, LPI_ON, LPI_DONE} lpi_state_type;

endpackage : mac_eee_pkg

// ### rtl/eee_sync2.sv
// Purpose: two flip-flop level synchroniser
// Assumes: each bit is an independent slow level
// Notes:   the first stage feeds only the second
`timescale 1ns/10ps
module eee_sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // level in and out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule : eee_sync2

// ### rtl/eee_link_side.sv
// Purpose: gmii-facing lpi signalling, tx clock halt and rx lpi decode
// Assumes: link_clk_i runs free; all control inputs are slow sys levels
// Notes:   clock gate uses a falling-edge enable so the output never glitches
`timescale 1ns/10ps
module eee_link_side
  import mac_eee_pkg::*;
(
  // clock and reset
  input  wire logic         link_clk_i,
  input  wire logic         rst_b_i,
  // levels from the sys domain
  input  wire logic         tx_lpi_i,
  input  wire logic         halt_en_i,
  input  wire logic         eee_on_i,
  // gmii pins
  input  wire gmii_rx_type  gmii_rx_i,
  output logic              gmii_gtx_clk_o,
  output logic        [7:0] gmii_txd_o,
  output logic              gmii_tx_er_o,
  // decoded level back to the sys domain
  output logic              rx_lpi_o
);
  logic        rst_meta_ff;
  logic        rst_b_ff;
  logic [2:0]  ctl_sync;
  gmii_rx_type rx_sync;
  logic        run_ff;
  logic        rx_lpi_ff;
  logic [7:0]  txd_ff;
  logic        tx_er_ff;
  wire         rx_lpi_code;

  // ------------------------------------------------------------
  // reset and crossings
  // ------------------------------------------------------------
  always_ff @(posedge link_clk_i)
  begin
    rst_meta_ff <= rst_b_i;
    rst_b_ff    <= rst_meta_ff;
  end

  eee_sync2 #(.W(3)) u_ctl_sync (
    .clk_i   (link_clk_i),
    .rst_b_i (rst_b_ff),
    .d_i     ({tx_lpi_i, halt_en_i, eee_on_i}),
    .q_o     (ctl_sync)
  );

  eee_sync2 #(.W(10)) u_rx_sync (
    .clk_i   (link_clk_i),
    .rst_b_i (rst_b_ff),
    .d_i     (gmii_rx_i),
    .q_o     (rx_sync)
  );

  // ------------------------------------------------------------
  // lpi signalling and decode
  // ------------------------------------------------------------
  // decode does not look at the receiver enable at all
  assign rx_lpi_code = ctl_sync[0] && !rx_sync.dv && rx_sync.er
                       && (rx_sync.d == GMII_LPI_CODE);

  always_ff @(posedge link_clk_i)
  begin
    if (!rst_b_ff)
    begin
      txd_ff    <= GMII_IDLE_CODE;
      tx_er_ff  <= 1'b0;
      rx_lpi_ff <= 1'b0;
    end
    else
    begin
      txd_ff    <= ctl_sync[2] ? GMII_LPI_CODE : GMII_IDLE_CODE;
      tx_er_ff  <= ctl_sync[2];
      rx_lpi_ff <= rx_lpi_code;
    end
  end

  // stop only while lpi is being signalled and the halt is allowed
  always_ff @(negedge link_clk_i)
  begin
    if (!rst_b_ff)
      run_ff <= 1'b1;
    else
      run_ff <= !(ctl_sync[2] && ctl_sync[1]);
  end

  assign gmii_gtx_clk_o = link_clk_i & run_ff;
  assign gmii_txd_o     = txd_ff;
  assign gmii_tx_er_o   = tx_er_ff;
  assign rx_lpi_o       = rx_lpi_ff;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  // checked on the gate's own edge so the pin level is the gated high phase
  halt_pin_a: assert property (@(negedge link_clk_i) disable iff (!rst_b_ff)
                               ctl_sync[2] && ctl_sync[1] |=> !gmii_gtx_clk_o)
    else $error("gtx clock running during halted lpi");
endmodule : eee_link_side

// ### rtl/mac_eee_duplex_control.sv
// Purpose: mac control register slice for eee and duplex, axi4-lite slave
// Assumes: one write and one read outstanding at most
// Notes:   link side runs on link_clk_i, sys crossings are single-bit levels, gmii rx is synchronised as a 10-bit bus
`timescale 1ns/10ps

// Functional notes
// - with clock halt set, stop the gigabit tx clock during tx lpi.
// - clock halt has no effect at 100 Mbps; clock keeps running.
// - eee enable turns lpi operation on; clearing it turns it fully off.
// - lpi requests and lpi decode ignore transmitter and receiver enables.
// - auto exit ends tx lpi after the programmed delay from its start.
// - polarity bit picks led level meaning full duplex; resets to one.
// - auto duplex ignores duplex bit, uses led, writes result back.
// - without auto duplex, the software duplex bit sets the mode.
// - protected fields survive a protected soft reset.
module mac_eee_duplex_control
  import mac_eee_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              link_clk_i,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] awaddr_i,
  input  wire logic              awvalid_i,
  output logic                   awready_o,
  input  wire logic [31:0]       wdata_i,
  input  wire logic [3:0]        wstrb_i,
  input  wire logic              wvalid_i,
  output logic                   wready_o,
  output logic [1:0]             bresp_o,
  output logic                   bvalid_o,
  input  wire logic              bready_i,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] araddr_i,
  input  wire logic              arvalid_i,
  output logic                   arready_o,
  output logic [31:0]            rdata_o,
  output logic [1:0]             rresp_o,
  output logic                   rvalid_o,
  input  wire logic              rready_i,
  // phy pins
  input  wire logic              full_duplex_led_i,
  input  wire gmii_rx_type       gmii_rx_i,
  output logic                   gmii_gtx_clk_o,
  output logic [7:0]             gmii_txd_o,
  output logic                   gmii_tx_er_o,
  // mac datapath controls
  output logic                   full_duplex_o,
  output logic                   receiver_on_o,
  output logic                   transmitter_on_o
);
  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[8*i +: 8] = new_w[8*i +: 8];
    return res;
  endfunction : merge

  function automatic logic [31:0] ctl_word(input mac_control_type c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CTL_CLK_HALT_BIT]  = c.clk_halt;
    w[CTL_EEE_ON_BIT]    = c.eee_on;
    w[CTL_AUTO_EXIT_BIT] = c.auto_exit;
    w[CTL_DPX_POL_BIT]   = c.dpx_pol;
    w[CTL_AUTO_DPX_BIT]  = c.auto_dpx;
    return w;
  endfunction : ctl_word

  function automatic logic [31:0] aux_word(input aux_control_type a);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[AUX_DPX_BIT]      = a.duplex_mode_bit;
    w[AUX_RX_ON_BIT]    = a.rx_on;
    w[AUX_TX_ON_BIT]    = a.tx_on;
    w[AUX_LINK_100_BIT] = a.link_100;
    w[AUX_LPI_REQ_BIT]  = a.lpi_req;
    w[AUX_PROTECT_BIT]  = a.protect;
    return w;
  endfunction : aux_word

  localparam mac_control_type CTL_RST = '{RST_CLK_HALT, RST_EEE_ON, RST_AUTO_EXIT,
                                          RST_DPX_POL, RST_AUTO_DPX};

  mac_control_type     ctl_ff;
  aux_control_type     aux_ff;
  logic [31:0]         delay_ff;
  logic                soft_rst_ff;
  logic                aw_hold_ff;
  logic                w_hold_ff;
  logic [ADDR_W-1:0]   awaddr_ff;
  logic [31:0]         wdata_ff;
  logic [3:0]          wstrb_ff;
  logic                bvalid_ff;
  logic [1:0]          bresp_ff;
  logic                rvalid_ff;
  logic [31:0]         rdata_ff;
  logic [1:0]          rresp_ff;
  lpi_state_type       lpi_state_ff;
  lpi_state_type       nxt_lpi_state;
  logic [31:0]         lpi_cnt_ff;
  logic                led_sync;
  logic                rx_lpi_sync;
  logic                rx_lpi_link;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire              aw_hs     = awvalid_i && awready_o;
  wire              w_hs      = wvalid_i && wready_o;
  wire              ar_hs     = arvalid_i && arready_o;
  wire              aw_have   = aw_hold_ff || aw_hs;
  wire              w_have    = w_hold_ff || w_hs;
  wire              do_write  = aw_have && w_have && !bvalid_ff;
  wire [ADDR_W-1:0] waddr     = aw_hold_ff ? awaddr_ff : awaddr_i;
  wire [31:0]       wdata     = w_hold_ff ? wdata_ff : wdata_i;
  wire [3:0]        wstrb     = w_hold_ff ? wstrb_ff : wstrb_i;
  wire              wr_ctl    = do_write && (waddr == OFF_MAC_CONTROL);
  wire              wr_aux    = do_write && (waddr == OFF_AUX_CONTROL);
  wire              wr_delay  = do_write && (waddr == OFF_EXIT_DELAY);
  wire              wr_map    = wr_ctl || wr_aux || wr_delay
                                || (waddr == OFF_STATUS);
  wire [31:0]       ctl_new   = merge(ctl_word(ctl_ff), wdata, wstrb);
  wire [31:0]       aux_new   = merge(aux_word(aux_ff), wdata, wstrb);
  wire              soft_req  = wr_aux && wstrb[0] && wdata[AUX_SOFT_RST_BIT];

  // ------------------------------------------------------------
  // block state seen by software
  // ------------------------------------------------------------
  wire tx_lpi_active = (lpi_state_ff == LPI_ON);
  wire led_full      = !(led_sync ^ ctl_ff.dpx_pol);
  wire halt_en       = ctl_ff.clk_halt && !aux_ff.link_100;
  wire rx_lpi_seen   = rx_lpi_sync && ctl_ff.eee_on;
  wire [31:0] ctl_rd = ctl_word(ctl_ff);
  wire [31:0] sts_rd = {28'h000_0000, halt_en && tx_lpi_active, full_duplex_o,
                        rx_lpi_seen, tx_lpi_active};

  wire [31:0] rd_mux = (araddr_i == OFF_MAC_CONTROL) ? ctl_rd
                     : (araddr_i == OFF_AUX_CONTROL) ? aux_word(aux_ff)
                     : (araddr_i == OFF_EXIT_DELAY)  ? delay_ff
                     : (araddr_i == OFF_STATUS)      ? sts_rd : 32'h0000_0000;
  wire rd_map = (araddr_i == OFF_MAC_CONTROL) || (araddr_i == OFF_AUX_CONTROL)
                || (araddr_i == OFF_EXIT_DELAY) || (araddr_i == OFF_STATUS);

  // ------------------------------------------------------------
  // axi write and read channels
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
        awaddr_ff <= awaddr_i;
      if (w_hs)
      begin
        wdata_ff <= wdata_i;
        wstrb_ff <= wstrb_i;
      end
      aw_hold_ff <= aw_have && !do_write;
      w_hold_ff  <= w_have && !do_write;
      if (do_write)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready_i)
        bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready_i)
      rvalid_ff <= 1'b0;
  end

  assign awready_o = !aw_hold_ff && !bvalid_ff;
  assign wready_o  = !w_hold_ff && !bvalid_ff;
  assign bvalid_o  = bvalid_ff;
  assign bresp_o   = bresp_ff;
  assign arready_o = !rvalid_ff;
  assign rvalid_o  = rvalid_ff;
  assign rdata_o   = rdata_ff;
  assign rresp_o   = rresp_ff;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // protected fields keep their value over a soft reset while protect is set
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
      ctl_ff <= CTL_RST;
    else if (soft_rst_ff && !aux_ff.protect)
      ctl_ff <= CTL_RST;
    else if (wr_ctl)
      ctl_ff <= '{ctl_new[CTL_CLK_HALT_BIT], ctl_new[CTL_EEE_ON_BIT],
                  ctl_new[CTL_AUTO_EXIT_BIT], ctl_new[CTL_DPX_POL_BIT],
                  ctl_new[CTL_AUTO_DPX_BIT]};
  end

  // detected duplex overrides any software write of the duplex bit
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i || soft_rst_ff)
    begin
      aux_ff    <= '0;
      soft_rst_ff <= 1'b0;
      if (rst_b_i)
        aux_ff.protect <= aux_ff.protect;
    end
    else
    begin
      soft_rst_ff <= soft_req;
      if (wr_aux)
        aux_ff <= '{aux_new[AUX_DPX_BIT], aux_new[AUX_RX_ON_BIT], aux_new[AUX_TX_ON_BIT],
                    aux_new[AUX_LINK_100_BIT], aux_new[AUX_LPI_REQ_BIT],
                    aux_new[AUX_PROTECT_BIT]};
      if (ctl_ff.auto_dpx)
        aux_ff.duplex_mode_bit <= led_full;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i || soft_rst_ff)
      delay_ff <= RST_EXIT_DELAY;
    else if (wr_delay)
      delay_ff <= merge(delay_ff, wdata, wstrb);
  end

  assign full_duplex_o    = ctl_ff.auto_dpx ? led_full : aux_ff.duplex_mode_bit;
  assign receiver_on_o    = aux_ff.rx_on;
  assign transmitter_on_o = aux_ff.tx_on;

  // ------------------------------------------------------------
  // transmit lpi sequencing
  // ------------------------------------------------------------
  // a zero delay still gives one cycle of lpi so the phy sees the entry
  wire lpi_go      = ctl_ff.eee_on && aux_ff.lpi_req;
  wire exit_expire = ctl_ff.auto_exit && ((lpi_cnt_ff + 32'h1) >= delay_ff);

  always_comb
  begin
    nxt_lpi_state = lpi_state_ff;
    unique case (lpi_state_ff)
      LPI_OFF:  if (lpi_go) nxt_lpi_state = LPI_ON;
      LPI_ON:   if (!lpi_go) nxt_lpi_state = LPI_OFF;
                else if (exit_expire) nxt_lpi_state = LPI_DONE;
      LPI_DONE: if (!lpi_go) nxt_lpi_state = LPI_OFF;
      default:  nxt_lpi_state = LPI_OFF;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      lpi_state_ff <= LPI_OFF;
      lpi_cnt_ff   <= 32'h0000_0000;
    end
    else
    begin
      lpi_state_ff <= nxt_lpi_state;
      lpi_cnt_ff   <= tx_lpi_active ? lpi_cnt_ff + 32'h1 : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // pins and link domain
  // ------------------------------------------------------------
  eee_sync2 #(.W(1)) u_led_sync (
    .clk_i   (sys_clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (full_duplex_led_i),
    .q_o     (led_sync)
  );

  eee_sync2 #(.W(1)) u_rx_lpi_sync (
    .clk_i   (sys_clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (rx_lpi_link),
    .q_o     (rx_lpi_sync)
  );

  eee_link_side u_link (
    .link_clk_i     (link_clk_i),
    .rst_b_i        (rst_b_i),
    .tx_lpi_i       (tx_lpi_active),
    .halt_en_i      (halt_en),
    .eee_on_i       (ctl_ff.eee_on),
    .gmii_rx_i      (gmii_rx_i),
    .gmii_gtx_clk_o (gmii_gtx_clk_o),
    .gmii_txd_o     (gmii_txd_o),
    .gmii_tx_er_o   (gmii_tx_er_o),
    .rx_lpi_o       (rx_lpi_link)
  );

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  logic [31:0] on_len_ff;
  always_ff @(posedge sys_clk_i)
    on_len_ff <= (!rst_b_i || !tx_lpi_active) ? 32'h0000_0000 : on_len_ff + 32'h1;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  halt_gate_a: assert property (tx_lpi_active && ctl_ff.clk_halt && !aux_ff.link_100
                                |-> sts_rd[STS_HALT_BIT])
    else $error("clock halt not requested during lpi");
  halt_100_a: assert property (aux_ff.link_100 |-> !halt_en && !sts_rd[STS_HALT_BIT])
    else $error("clock halt requested at 100 mbps");
  eee_off_a: assert property (!ctl_ff.eee_on |=> !tx_lpi_active)
    else $error("lpi active with eee disabled");
  lpi_no_transmitter_on_a: assert property (lpi_go && !aux_ff.tx_on && lpi_state_ff == LPI_OFF
                                  |=> tx_lpi_active)
    else $error("lpi request not issued");
  auto_exit_a: assert property (ctl_ff.auto_exit && $stable(delay_ff)
                                && delay_ff != 0 |-> on_len_ff <= delay_ff)
    else $error("lpi outlived auto exit delay");
  dpx_pol_a: assert property ($rose(rst_b_i) |-> ctl_ff.dpx_pol)
    else $error("polarity bit reset value wrong");
  auto_dpx_a: assert property (ctl_ff.auto_dpx && !soft_rst_ff
                               |=> aux_ff.duplex_mode_bit == $past(led_full))
    else $error("detected duplex not written back");
  manual_dpx_a: assert property (!ctl_ff.auto_dpx |-> full_duplex_o == aux_ff.duplex_mode_bit)
    else $error("duplex not taken from software bit");
  protect_a: assert property (soft_rst_ff && aux_ff.protect |=> $stable(ctl_ff))
    else $error("protected field lost on soft reset");
  reserved_a: assert property (ar_hs && araddr_i == OFF_MAC_CONTROL
                               |=> rdata_o[31:19] == 13'h0000 && rdata_o[15:14] == 2'h0
                               && rdata_o[11:0] == 12'h000)
    else $error("reserved control bits not zero");
endmodule : mac_eee_duplex_control

// ### dv/eee_phy_model.sv
// Purpose: phy model for the gmii pins and the duplex led
// Assumes: rx lpi arrives as dv low, er high, data 01
// Notes:   the bench commands the led level and rx lpi
`timescale 1ns/10ps
module eee_phy_model
  import mac_eee_pkg::*;
(
  // gmii side
  input  wire logic       link_clk_i,
  input  wire logic [7:0] txd_i,
  input  wire logic       tx_er_i,
  output gmii_rx_type     gmii_rx_o,
  output logic            tx_lpi_o,
  // bench side
  input  wire logic       rx_lpi_i,
  input  wire logic       led_i,
  output logic            led_o
);
  assign led_o = led_i;
  // tx lpi counts only when error flag and code agree
  assign tx_lpi_o = tx_er_i && (txd_i == GMII_LPI_CODE);
  always_ff @(posedge link_clk_i)
    gmii_rx_o <= rx_lpi_i ? {2'h1, GMII_LPI_CODE} : {2'h0, GMII_IDLE_CODE};
endmodule : eee_phy_model

// ### dv/tb.sv
// Purpose: self-checking bench for the eee and duplex control block
// Assumes: axi4-lite master on sys clock, free link clock of 6 ns
// Notes:   fixed waits cover the known sync latency, the auto exit delay and the gtx count windows
`timescale 1ns/10ps
module tb
  import mac_eee_pkg::*;
();
  logic        clk = 1'h0, lclk = 1'h0, rst_b = 1'h0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, gtx, txer, fdx, rxon, txon, led, tlpi;
  logic        rx_cmd = 1'h0, led_lvl = 1'h0;
  logic [1:0]  bresp, rresp, wresp;
  logic [7:0]  txd;
  gmii_rx_type grx;
  int          failures = 0, checks_done = 0, gtx_cnt = 0;

  always #2.5 clk = ~clk;
  always #3 lclk = ~lclk;
  always @(posedge gtx) gtx_cnt++;

  mac_eee_duplex_control i_mac_eee_duplex_control (
    .sys_clk_i(clk), .rst_b_i(rst_b), .link_clk_i(lclk),
    .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready),
    .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid), .wready_o(wready),
    .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
    .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
    .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready),
    .full_duplex_led_i(led), .gmii_rx_i(grx), .gmii_gtx_clk_o(gtx), .gmii_txd_o(txd),
    .gmii_tx_er_o(txer), .full_duplex_o(fdx), .receiver_on_o(rxon),
    .transmitter_on_o(txon));

  eee_phy_model i_eee_phy_model (
    .link_clk_i(lclk), .txd_i(txd), .tx_er_i(txer), .gmii_rx_o(grx), .tx_lpi_o(tlpi),
    .rx_lpi_i(rx_cmd), .led_i(led_lvl), .led_o(led));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // address and data are released separately, each when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit da, dw, ta, tw;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(da && dw))
    begin
      @(negedge clk);
      ta = awready && !da;
      tw = wready && !dw;
      @(posedge clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      da |= ta;
      dw |= tw;
    end
    do @(negedge clk); while (!bvalid);
    wresp = bresp;
    @(posedge clk);
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'h0;
    do @(negedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'h0;
  endtask : rd

  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d & m, e);
  endtask : rdc

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rdc(12'h100, 32'hffff_ffff, 32'h0000_2000);
    wr(12'h100, 32'hfffd_ffff);
    chk({30'h0, wresp}, {30'h0, RESP_OKAY});
    rdc(12'h100, 32'hffff_ffff, 32'h0005_3000);
    wr(12'h100, 32'h0000_2000);
    rd(12'h200, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(12'h200, 32'h0000_0000);
    chk({30'h0, wresp}, {30'h0, RESP_SLVERR});
    $display("t_regs done");
  endtask : t_regs

  task automatic t_halt;
    int n;
    wr(12'h100, 32'h0006_2000); // model phy tolerates a stopped clock
    wr(12'h104, 32'h0000_0010);
    repeat (10) @(posedge clk);
    rdc(12'h10c, 32'h0000_000f, 32'h0000_0009);
    chk({31'h0, tlpi}, 32'h1);
    n = gtx_cnt;
    repeat (10) @(posedge clk);
    chk(gtx_cnt - n, 32'h0);
    wr(12'h104, 32'h0000_0018);
    repeat (10) @(posedge clk);
    n = gtx_cnt;
    repeat (10) @(posedge clk);
    chk({31'h0, gtx_cnt > n}, 32'h1);
    wr(12'h100, 32'h0004_2000);
    repeat (10) @(posedge clk);
    chk({31'h0, tlpi}, 32'h0);
    wr(12'h104, 32'h0);
    $display("t_halt done");
  endtask : t_halt

  task automatic t_exit;
    wr(12'h108, 32'h0000_0014);
    wr(12'h100, 32'h0001_2000); // auto exit set while eee is off
    wr(12'h100, 32'h0003_2000);
    wr(12'h104, 32'h0000_0010);
    rdc(12'h10c, 32'h1, 32'h1);
    repeat (30) @(posedge clk);
    rdc(12'h10c, 32'h1, 32'h0);
    wr(12'h104, 32'h0);
    wr(12'h100, 32'h0001_2000);
    wr(12'h100, 32'h0000_2000);
    $display("t_exit done");
  endtask : t_exit

  task automatic t_rx;
    wr(12'h100, 32'h0002_2000);
    rx_cmd <= 1'h1;
    repeat (12) @(posedge clk);
    rdc(12'h10c, 32'h2, 32'h2);
    wr(12'h100, 32'h0000_2000);
    repeat (12) @(posedge clk);
    rdc(12'h10c, 32'h2, 32'h0);
    rx_cmd <= 1'h0;
    $display("t_rx done");
  endtask : t_rx

  task automatic t_dpx;
    led_lvl <= 1'h1;
    wr(12'h100, 32'h0000_3000);
    repeat (5) @(posedge clk);
    chk({31'h0, fdx}, 32'h1);
    rdc(12'h104, 32'h1, 32'h1);
    wr(12'h100, 32'h0000_1000); // receiver and transmitter are off here
    wr(12'h104, 32'h0000_0001);
    repeat (5) @(posedge clk);
    chk({31'h0, fdx}, 32'h0);
    wr(12'h100, 32'h0000_2000);
    wr(12'h104, 32'h0000_0007);
    repeat (2) @(posedge clk);
    chk({29'h0, fdx, rxon, txon}, 32'h7);
    wr(12'h104, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, fdx}, 32'h0);
    led_lvl <= 1'h0;
    $display("t_dpx done");
  endtask : t_dpx

  task automatic t_prot;
    wr(12'h100, 32'h0005_1000);
    wr(12'h104, 32'h0000_0020);
    wr(12'h104, 32'h0000_0060);
    repeat (3) @(posedge clk);
    rdc(12'h100, 32'hffff_ffff, 32'h0005_1000);
    wr(12'h104, 32'h0);
    wr(12'h104, 32'h0000_0040);
    repeat (3) @(posedge clk);
    rdc(12'h100, 32'hffff_ffff, 32'h0000_2000);
    $display("t_prot done");
  endtask : t_prot

  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    t_regs;
    t_halt;
    t_exit;
    t_rx;
    t_dpx;
    t_prot;
    end_sim;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("unexpected at %0t: timeout", $time);
    end_sim;
  end
endmodule : tb
